// File: ial_cfg.svh
// constants for the integer add and logic unit
`ifndef IAL_CFG_SVH
`define IAL_CFG_SVH
`define IAL_PC_STEP 32'h0000_0002
`define IAL_PC_RST 32'h0000_0000
`define IAL_GBP_RST 32'h0000_0000
`define IAL_REG_RST 32'h0000_0000
`define IAL_TAIL_LEN 2'h3
`define IAL_MEM_CYCLES 2'h3
`define IAL_OP_ADD_REG 16'h300c
`define IAL_OP_ADD_WITH_CARRY 16'h300e
`define IAL_OP_ADD_OVERFLOW_CHECK 16'h300f
`define IAL_OP_AND_REG 16'h2009
`define IAL_MASK_RR 16'hf00f
`define IAL_OP_ADD_IMM 16'h7000
`define IAL_MASK_NIB 16'hf000
`define IAL_OP_AND_IMM 16'hc900
`define IAL_OP_AND_MEM 16'hcd00
`define IAL_MASK_BYTE 16'hff00
`define IAL_OP_BRA 16'ha000
`define IAL_OP_BTS 16'h8d00
`define IAL_OP_BFS 16'h8f00
`define IAL_OP_BT 16'h8900
`define IAL_OP_BF 16'h8b00
`endif

// File: ial_pkg.sv
// types of the integer add and logic unit
package ial_pkg;
  // decoded instruction class
  typedef enum logic [3:0] {
    IAL_K_ADD, IAL_K_ADDI, IAL_K_ADD_WITH_CARRY, IAL_K_ADD_OVERFLOW_CHECK, IAL_K_AND, IAL_K_ANDI,
    IAL_K_ANDM, IAL_K_BRD, IAL_K_BRN, IAL_K_SYS, IAL_K_ILL
  } ial_kind_t;
  // fetched instruction word with context
  typedef struct packed {
    logic [15:0] word;
    logic in_tail;
  } ial_instr_t;
  // byte memory access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
  } ial_mem_t;
  // displacement scaling operand size
  typedef enum logic [1:0] {IAL_SZ_B = 2'h0, IAL_SZ_W = 2'h1, IAL_SZ_L = 2'h2} ial_size_t;
endpackage

// File: ial_decode.sv
// instruction decoder and displacement scaler
`timescale 1ns/1ns
`default_nettype none
`include "ial_cfg.svh"
module ial_decode (
  input wire logic [15:0] word_in, // instruction word
  input wire logic [7:0] disp_in, // raw displacement
  input wire ial_pkg::ial_size_t size_in, // operand size
  output ial_pkg::ial_kind_t kind_out, // decoded class
  output logic [31:0] disp_scaled_out // scaled displacement
);
  import ial_pkg::*;
  // match a word against pattern under mask
  function automatic logic ial_match(input logic [15:0] w, input logic [15:0] m,
                                     input logic [15:0] p);
    ial_match = ((w & m) == p);
  endfunction
  // class decode, unassigned codes are illegal
  always_comb begin
    if (ial_match(word_in, `IAL_MASK_RR, `IAL_OP_ADD_REG)) kind_out = IAL_K_ADD;
    else if (ial_match(word_in, `IAL_MASK_RR, `IAL_OP_ADD_WITH_CARRY)) kind_out = IAL_K_ADD_WITH_CARRY;
    else if (ial_match(word_in, `IAL_MASK_RR, `IAL_OP_ADD_OVERFLOW_CHECK)) kind_out = IAL_K_ADD_OVERFLOW_CHECK;
    else if (ial_match(word_in, `IAL_MASK_RR, `IAL_OP_AND_REG)) kind_out = IAL_K_AND;
    else if (ial_match(word_in, `IAL_MASK_NIB, `IAL_OP_ADD_IMM)) kind_out = IAL_K_ADDI;
    else if (ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_AND_IMM)) kind_out = IAL_K_ANDI;
    else if (ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_AND_MEM)) kind_out = IAL_K_ANDM;
    else if (ial_match(word_in, `IAL_MASK_NIB, `IAL_OP_BRA) ||
             ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_BTS) ||
             ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_BFS)) kind_out = IAL_K_BRD;
    else if (ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_BT) ||
             ial_match(word_in, `IAL_MASK_BYTE, `IAL_OP_BF)) kind_out = IAL_K_BRN;
    else kind_out = IAL_K_ILL;
  end
  // displacement scaled by operand size
  always_comb begin
    case (size_in)
      IAL_SZ_W: disp_scaled_out = {23'h0, disp_in, 1'h0};
      IAL_SZ_L: disp_scaled_out = {22'h0, disp_in, 2'h0};
      default: disp_scaled_out = {24'h0, disp_in};
    endcase
  end
endmodule // ial_decode
`default_nettype wire

// File: ial_unit.sv
// integer add and logic execution unit
`timescale 1ns/1ns
`default_nettype none
`include "ial_cfg.svh"
module ial_unit #(
  parameter int NREG = 16 // general register count
) (
  input wire logic ref_clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic instr_valid_in, // instruction offered
  input wire ial_pkg::ial_instr_t instr_in, // word and loop-tail flag
  input wire logic [31:0] branch_target_in, // delayed branch target
  input wire logic status_write_in, // word updates status or repeat regs
  input wire logic [7:0] mem_rdata_in, // byte read data
  input wire logic [7:0] disp_in, // raw displacement
  input wire ial_pkg::ial_size_t size_in, // operand size
  input wire logic int_req_in, // pending interrupt
  input wire logic addr_err_in, // pending address error
  output logic instr_ready_out, // unit can take an instruction
  output ial_pkg::ial_mem_t mem_out, // byte access request
  output logic illegal_out, // illegal-instruction exception pulse
  output logic int_take_out, // interrupt accepted pulse
  output logic addr_err_take_out, // address error accepted pulse
  output logic [31:0] pc_out, // program counter
  output logic flag_out, // condition flag
  output logic [31:0] reg_zero_out, // register zero view
  output logic [31:0] disp_scaled_out // scaled displacement
);
  import ial_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IAL_S_RUN = 3'h1, IAL_S_RD = 3'h2, IAL_S_WR = 3'h4
  } ial_state_t;
  ial_state_t state_r;
  logic [31:0] gpr_r [NREG];
  logic [31:0] gbp_r;
  logic [31:0] tgt_r;
  logic [7:0] imm_r;
  logic [31:0] maddr_r;
  logic slot_r;
  logic flag_r;
  ial_kind_t kind;
  logic [31:0] disp_w;
  logic [3:0] rn;
  logic [3:0] rm;
  logic [31:0] a;
  logic [31:0] b;
  logic [32:0] sum;
  logic [31:0] simm;
  logic bad;
  logic go;
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  ial_decode u_dec (
    .word_in(instr_in.word),
    .disp_in(disp_in),
    .size_in(size_in),
    .kind_out(kind),
    .disp_scaled_out(disp_w)
  );
  // operand selection and adder
  assign rn = instr_in.word[11:8];
  assign rm = instr_in.word[7:4];
  assign a = gpr_r[rn];
  assign b = gpr_r[rm];
  assign simm = {{24{instr_in.word[7]}}, instr_in.word[7:0]};
  always_comb begin
    case (kind)
      IAL_K_ADD_WITH_CARRY: sum = {1'h0, a} + {1'h0, b} + {32'h0, flag_r};
      IAL_K_ADDI: sum = {1'h0, a} + {1'h0, simm};
      default: sum = {1'h0, a} + {1'h0, b};
    endcase
  end
  // exception conditions
  assign bad = (kind == IAL_K_ILL) ||
               (slot_r && (kind == IAL_K_BRD || kind == IAL_K_BRN)) ||
               (instr_in.in_tail && (kind == IAL_K_ILL || kind == IAL_K_BRD ||
                kind == IAL_K_BRN || status_write_in));
  assign go = instr_valid_in && (state_r == IAL_S_RUN);
  // ---------------------------------------------------------------
  // register file and flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NREG; i++) gpr_r[i] <= `IAL_REG_RST;
    end else if (go && !bad) begin
      case (kind)
        IAL_K_ADD, IAL_K_ADDI, IAL_K_ADD_WITH_CARRY, IAL_K_ADD_OVERFLOW_CHECK: gpr_r[rn] <= sum[31:0];
        IAL_K_AND: gpr_r[rn] <= a & b;
        IAL_K_ANDI: gpr_r[0] <= gpr_r[0] & {24'h0, instr_in.word[7:0]};
        default: ;
      endcase
    end
  end
  // condition flag: only carry and overflow adds touch it
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) flag_r <= 1'h0;
    else if (go && !bad && kind == IAL_K_ADD_WITH_CARRY) flag_r <= sum[32];
    else if (go && !bad && kind == IAL_K_ADD_OVERFLOW_CHECK)
      flag_r <= (a[31] == b[31]) && (sum[31] != a[31]);
  end
  assign gbp_r = `IAL_GBP_RST;
  // ---------------------------------------------------------------
  // byte read-modify-write sequence
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= IAL_S_RUN;
      imm_r <= 8'h00;
      maddr_r <= 32'h0;
    end else begin
      case (state_r)
        IAL_S_RUN: if (go && !bad && kind == IAL_K_ANDM) begin
          state_r <= IAL_S_RD;
          imm_r <= instr_in.word[7:0];
          maddr_r <= gbp_r + gpr_r[0];
        end
        IAL_S_RD: state_r <= IAL_S_WR;
        IAL_S_WR: state_r <= IAL_S_RUN;
        default: state_r <= IAL_S_RUN;
      endcase
    end
  end
  // memory port, registered
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) mem_out <= '0;
    else begin
      mem_out.rd <= (state_r == IAL_S_RUN) && go && !bad && kind == IAL_K_ANDM;
      mem_out.wr <= (state_r == IAL_S_RD);
      mem_out.addr <= (state_r == IAL_S_RUN) ? gbp_r + gpr_r[0] : maddr_r;
      mem_out.wdata <= mem_rdata_in & imm_r;
    end
  end
  // ---------------------------------------------------------------
  // program counter, delay slot and events
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out <= `IAL_PC_RST;
      slot_r <= 1'h0;
      tgt_r <= 32'h0;
    end else if (go && !bad) begin
      if (kind == IAL_K_BRD) begin
        tgt_r <= branch_target_in;
        slot_r <= 1'h1;
        pc_out <= pc_out + `IAL_PC_STEP;
      end else if (slot_r) begin
        slot_r <= 1'h0;
        pc_out <= tgt_r;
      end else pc_out <= pc_out + `IAL_PC_STEP;
    end else if (go) slot_r <= 1'h0;
  end
  // event pulses; interrupts and address errors held off in the slot
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      illegal_out <= 1'h0;
      int_take_out <= 1'h0;
      addr_err_take_out <= 1'h0;
      instr_ready_out <= 1'h0;
      flag_out <= 1'h0;
      reg_zero_out <= 32'h0;
      disp_scaled_out <= 32'h0;
    end else begin
      illegal_out <= go && bad;
      int_take_out <= int_req_in && !slot_r && !(go && kind == IAL_K_BRD);
      addr_err_take_out <= addr_err_in && !slot_r && !(go && kind == IAL_K_BRD);
      instr_ready_out <= (state_r == IAL_S_RUN) && !(go && kind == IAL_K_ANDM);
      flag_out <= flag_r;
      reg_zero_out <= gpr_r[0];
      disp_scaled_out <= disp_w;
    end
  end
endmodule // ial_unit
`default_nettype wire

// File: ial_unit_asserts.sv
// checker for the integer add and logic unit ports
`timescale 1ns/1ns
`default_nettype none
module ial_unit_chk (
  input wire logic ref_clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic instr_valid_in, // instruction offered
  input wire ial_pkg::ial_instr_t instr_in, // word and tail flag
  input wire logic status_write_in, // status write word
  input wire logic [7:0] mem_rdata_in, // byte read data
  input wire logic int_take_out, // interrupt accepted
  input wire logic addr_err_take_out, // address error accepted
  input wire logic illegal_out, // illegal pulse
  input wire ial_pkg::ial_mem_t mem_out, // byte access
  input wire logic [31:0] pc_out, // program counter
  input wire logic flag_out, // condition flag
  input wire logic [31:0] reg_zero_out // register zero
);
  import ial_pkg::*;
  logic [31:0] r0_d1, r0_d2, pc_d1, pc_d2;
  // views as they stood two edges back
  always_ff @(posedge ref_clk_in) begin
    r0_d1 <= reg_zero_out;
    r0_d2 <= r0_d1;
    pc_d1 <= pc_out;
    pc_d2 <= pc_d1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_UNASSIGNED_ILL: assert property (instr_valid_in && instr_in.word == 16'hffff
    |-> ##[1:2] illegal_out) else $error("unassigned word not refused");
  AST_ILL_KEEPS: assert property (illegal_out
    |-> $stable(reg_zero_out) && $stable(flag_out) && !mem_out.wr)
    else $error("refused word changed state");
  AST_TAIL_ILL: assert property (instr_valid_in && instr_in.in_tail && status_write_in
    |-> ##[1:2] illegal_out) else $error("status write in loop tail not refused");
  AST_ANDM_SEQ: assert property (instr_valid_in && instr_in.word[15:8] == 8'hcd
    |=> mem_out.rd && mem_out.addr == reg_zero_out ##1 mem_out.wr
    && mem_out.wdata == ($past(mem_rdata_in) & $past(instr_in.word[7:0], 2)))
    else $error("byte and sequence wrong");
  AST_ANDI_UPPER: assert property (instr_valid_in && instr_in.word[15:8] == 8'hc9
    |-> ##2 reg_zero_out[31:8] == 24'h0) else $error("upper bits of register zero kept");
  AST_ADD_OVERFLOW_CHECK_FLAG: assert property (instr_valid_in && instr_in.word == 16'h300f
    |-> ##2 flag_out == (r0_d2[31] ^ r0_d2[30]) && reg_zero_out == r0_d2 + r0_d2)
    else $error("overflow add result wrong");
  AST_PC_STEP: assert property (instr_valid_in && instr_in.word[15:12] == 4'h7
    && !instr_in.in_tail |-> ##2 pc_out == pc_d2 + 32'h2) else $error("pc did not step by two");
  AST_NO_INT: assert property (instr_valid_in && instr_in.word[15:12] == 4'ha
    |=> (!int_take_out && !addr_err_take_out) [*3]) else $error("event taken before slot");
endmodule // ial_unit_chk
bind ial_unit ial_unit_chk u_chk (.ref_clk_in, .rst_n_in, .instr_valid_in, .instr_in,
  .status_write_in, .mem_rdata_in, .int_take_out, .addr_err_take_out, .illegal_out,
  .mem_out, .pc_out, .flag_out, .reg_zero_out);
`default_nettype wire

// File: ial_unit_bench.sv
// self-checking bench of the integer add and logic unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ial_unit_bench;
  import ial_pkg::*;
  logic ref_clk_in, rst_n_in, instr_valid_in, status_write_in, int_req_in, addr_err_in, iw;
  logic instr_ready_out, illegal_out, int_take_out, addr_err_take_out, flag_out;
  logic ill_seen, it_seen, busy_seen;
  ial_instr_t instr_in;
  ial_size_t size_in;
  ial_mem_t mem_out;
  logic [31:0] branch_target_in, pc_out, reg_zero_out, disp_scaled_out, exp_pc, rd_a;
  logic [39:0] wr_v;
  logic [7:0] mem_rdata_in, disp_in;
  int failures = 0, total_checks = 0, cyc = 0;
  ial_unit dut (.ref_clk_in, .rst_n_in, .instr_valid_in, .instr_in, .branch_target_in,
    .status_write_in, .mem_rdata_in, .disp_in, .size_in, .int_req_in, .addr_err_in,
    .instr_ready_out, .mem_out, .illegal_out, .int_take_out, .addr_err_take_out, .pc_out,
    .flag_out, .reg_zero_out, .disp_scaled_out);
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // offer one word, then watch four cycles
  task automatic exec(input logic [15:0] w, input logic tl, input logic sw);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= {w, tl};
    status_write_in <= sw;
    int_req_in <= iw;
    addr_err_in <= iw;
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    status_write_in <= 1'b0;
    {ill_seen, it_seen, busy_seen, rd_a, wr_v} = '0;
    repeat (4) begin
      #1;
      ill_seen |= illegal_out;
      busy_seen |= !instr_ready_out;
      it_seen |= int_take_out | addr_err_take_out;
      if (mem_out.rd) rd_a = mem_out.addr;
      if (mem_out.wr) wr_v = {mem_out.addr, mem_out.wdata};
      @(posedge ref_clk_in);
    end
    #1;
  endtask
  task automatic ok(input logic [15:0] w, input logic [31:0] r, input logic f);
    exec(w, 1'b0, 1'b0);
    exp_pc += 32'h2;
    `CHK({reg_zero_out, flag_out, pc_out, ill_seen}, {r, f, exp_pc, 1'b0})
  endtask
  task automatic bad(input logic [15:0] w, input logic tl, input logic sw);
    logic [31:0] r;
    logic f;
    r = reg_zero_out;
    f = flag_out;
    exec(w, tl, sw);
    `CHK({reg_zero_out, flag_out, ill_seen}, {r, f, 1'b1})
  endtask
  task automatic t_arith;
    ok(16'h7001, 32'h1, 1'b0);
    ok(16'h70fe, 32'hffff_ffff, 1'b0);
    ok(16'h300e, 32'hffff_fffe, 1'b1);
    ok(16'h301e, 32'hffff_ffff, 1'b0);
    ok(16'hc900, 32'h0, 1'b0);
    ok(16'h7001, 32'h1, 1'b0);
    for (int i = 1; i < 32; i++) ok(16'h300c, 32'h1 << i, 1'b0);
    ok(16'h300f, 32'h0, 1'b1);
    ok(16'h7001, 32'h1, 1'b1);
    ok(16'h2019, 32'h0, 1'b1);
    ok(16'h301f, 32'h0, 1'b0);
    $display("arith test done");
  endtask
  task automatic t_logic;
    ok(16'h70ff, 32'hffff_ffff, 1'b0);
    ok(16'hc90f, 32'hf, 1'b0);
    ok(16'h7001, 32'h10, 1'b0);
    @(posedge ref_clk_in);
    mem_rdata_in <= 8'ha5;
    exec(16'hcd80, 1'b0, 1'b0);
    exp_pc += 32'h2;
    `CHK({rd_a, wr_v, pc_out}, {32'h10, 32'h10, 8'h80, exp_pc})
    `CHK({busy_seen, instr_ready_out}, 2'b11)
    @(posedge ref_clk_in);
    mem_rdata_in <= 8'h5a;
    $display("logic test done");
  endtask
  task automatic t_refuse;
    bad(16'hffff, 1'b0, 1'b0);
    bad(16'h7001, 1'b1, 1'b1);
    bad(16'ha000, 1'b1, 1'b0);
    `CHK(pc_out, exp_pc)
    $display("refuse test done");
  endtask
  task automatic t_branch;
    iw = 1'b1;
    exec(16'ha000, 1'b0, 1'b0);
    `CHK(it_seen, 1'b0)
    @(posedge ref_clk_in);
    branch_target_in <= 32'h200;
    exec(16'h301c, 1'b0, 1'b0);
    `CHK({it_seen, pc_out}, {1'b1, 32'h100})
    iw = 1'b0;
    @(posedge ref_clk_in);
    {int_req_in, addr_err_in} <= 2'h0;
    exec(16'ha000, 1'b0, 1'b0);
    bad(16'hffff, 1'b0, 1'b0);
    exec(16'ha000, 1'b0, 1'b0);
    bad(16'ha000, 1'b0, 1'b0);
    $display("branch test done");
  endtask
  task automatic t_disp;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk_in);
      disp_in <= 8'h35;
      size_in <= ial_size_t'(s);
      repeat (2) @(posedge ref_clk_in);
      #1 `CHK(disp_scaled_out, 32'h35 << s)
    end
    $display("disp test done");
  endtask
  initial begin
    {rst_n_in, instr_valid_in, status_write_in, int_req_in, addr_err_in, iw} = '0;
    instr_in = '0;
    branch_target_in = 32'h100;
    {mem_rdata_in, disp_in} = '0;
    size_in = IAL_SZ_B;
    exp_pc = 32'h0;
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_arith();
    t_logic();
    t_refuse();
    t_branch();
    t_disp();
    report_and_stop();
  end
endmodule // ial_unit_bench
`default_nettype wire
